// [core/ldc_defs.svh]
// Constants for the forwarded-clock capture setup and status block.
// How it works
// R1: Host sets output power-down while clock missing.
// R2: Host picks stability value by clock rate.
// R3: Status bit 0 shows loop running.
// R4: Status bit 7 shows loop locked.
// R5: Status bit 2 shows valid forwarded clock.
// R6: Status bits 6..4 warn of poor sampling.
// R7: Status read returns a momentary snapshot.
// R8: Host turns off delay cell first.
// R9: Host writes stability, then loop control.
// R10: Writing 0xC0 enables loop, duty correction.
// R11: Locked loop reads 1000b in bits 7..4.
// R12: Host drives clock as alternating data lane.
// R13: Phase offset is sign-magnitude, 11.25 degree steps.
// R14: Loop runs 250-575 MHz, samples both edges.
// R15: Host streams only after lock and clock.
`ifndef LDC_DEFS_SVH
`define LDC_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define LDC_ADDR_PWR    7'h01
`define LDC_ADDR_CTL    7'h0A
`define LDC_ADDR_STAB   7'h0D
`define LDC_ADDR_STAT   7'h0E
`define LDC_ADDR_DLY    7'h5E

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define LDC_PWR_OFF_BIT 7
`define LDC_CTL_EN_BIT  7
`define LDC_CTL_DCC_BIT 6
`define LDC_CTL_SGN_BIT 3
`define LDC_STAB_SLOW   7
`define LDC_DLY_LSB_BIT 0
`define LDC_RST_PWR     8'h00
`define LDC_RST_CTL     8'h00
`define LDC_RST_STAB    8'h00
`define LDC_RST_DLY     8'h00
`define LDC_PH_WARN_MAG 3'h6
`define LDC_PH_BAD_MAG  3'h7

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define LDC_SYS_CLK_NS  4
`define LDC_CLK_LOSS_NS 480
`define LDC_CLK_LOSS_CYC (`LDC_CLK_LOSS_NS / `LDC_SYS_CLK_NS)
`define LDC_LOCK_FAST   8'h40
`define LDC_LOCK_SLOW   8'h80

`endif

// [core/ldc_pkg.sv]
// Types shared by the capture setup block.
package ldc_pkg;

  // Serial register port sequencer states.
  typedef enum logic [2:0] {
    LDC_SPI_IDLE  = 3'b001,
    LDC_SPI_INSTR = 3'b010,
    LDC_SPI_DATA  = 3'b100
  } ldc_spi_e;

  // Layout of the capture status byte.
  typedef struct packed {
    logic       locked;
    logic [2:0] warn;
    logic       zero3;
    logic       clk_ok;
    logic       zero1;
    logic       running;
  } ldc_status_s;

  // One double-rate sample pair.
  typedef struct packed {
    logic [15:0] rise;
    logic [15:0] fall;
  } ldc_sample_s;

endpackage

// [core/ldc_link.sv]
// Link-side loop model and double-edge capture on the forwarded data clock.
`include "ldc_defs.svh"

module ldc_link (
  // Link clock and system reset level
  input  wire logic          forwarded_data_clock_in,
  input  wire logic          reset_n_in,
  // Levels from the system domain
  input  wire logic          loop_en_in,
  input  wire logic          slow_in,
  input  wire logic          out_off_in,
  // Data lanes
  input  wire logic [15:0]   data_in,
  // Results
  output logic               lock_out,
  output logic               beat_out,
  output ldc_pkg::ldc_sample_s sample_out,
  output logic               valid_out
);

  logic [3:0]  cdc_a_q;
  logic [3:0]  cdc_b_q;
  logic        rst_n;
  logic        en;
  logic [7:0]  lock_cnt_q;
  logic [7:0]  target;
  logic [15:0] rise_q;
  logic [15:0] fall_q;

  // Two-flop crossing of the system-side levels; reset is released synchronously.
  always_ff @(posedge forwarded_data_clock_in) begin
    cdc_a_q <= {reset_n_in, loop_en_in, slow_in, out_off_in};
    cdc_b_q <= cdc_a_q;
  end

  assign rst_n  = cdc_b_q[3];
  assign en     = cdc_b_q[2];
  assign target = cdc_b_q[1] ? `LDC_LOCK_SLOW : `LDC_LOCK_FAST;

  // Heartbeat toggle lets the system side see that this clock is alive.
  always_ff @(posedge forwarded_data_clock_in) begin
    if (!rst_n) begin
      beat_out <= 1'b0;
    end else begin
      beat_out <= ~beat_out;
    end
  end

  // Lock acquisition: a slower clock takes longer to settle, so the count grows.
  always_ff @(posedge forwarded_data_clock_in) begin
    if (!rst_n || !en) begin
      lock_cnt_q <= 8'h00;
      lock_out   <= 1'b0;
    end else if (lock_cnt_q == target) begin
      lock_out   <= 1'b1; // R14
    end else begin
      lock_cnt_q <= lock_cnt_q + 8'h01;
    end
  end

  // Double-edge capture on the unshifted forwarded data clock.
  always_ff @(posedge forwarded_data_clock_in) begin
    rise_q <= data_in; // R14
  end

  always_ff @(negedge forwarded_data_clock_in) begin
    fall_q <= data_in; // R14
  end

  // Pairs are released only while locked and the output is powered.
  always_ff @(posedge forwarded_data_clock_in) begin
    if (!rst_n) begin
      sample_out <= '0;
      valid_out  <= 1'b0;
    end else begin
      sample_out <= {rise_q, fall_q};
      valid_out  <= lock_out & ~cdc_b_q[0];
    end
  end

  a_lock_drop: assert property (@(posedge forwarded_data_clock_in) disable iff (!rst_n) // R14
    !en |=> !lock_out)
    else $error("lock held with loop disabled");

  a_lock_reach: assert property (@(posedge forwarded_data_clock_in) disable iff (!rst_n) // R14
    (en && !lock_out && lock_cnt_q == target) ##1 en |-> lock_out)
    else $error("lock not reached at count target");

endmodule

// [core/ldc_top.sv]
// Capture setup registers, serial register port and clock supervision.
`include "ldc_defs.svh"

module ldc_top (
  // System clock and reset
  input  wire logic            clk_sys_in,
  input  wire logic            reset_n_in,
  // Serial register port pins
  input  wire logic            spi_sclk_in,
  input  wire logic            spi_cs_n_in,
  input  wire logic            spi_sdio_in,
  output logic                 spi_sdio_out,
  output logic                 spi_sdio_oe_out,
  // Source-synchronous link
  input  wire logic            forwarded_data_clock_in,
  input  wire logic [15:0]     lvds_data_in,
  output ldc_pkg::ldc_sample_s sample_out,
  output logic                 sample_valid_out,
  // Control outputs
  output logic                 output_current_off_out,
  output logic                 dcc_enable_out,
  output logic signed [4:0]    phase_step_out
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  localparam logic [7:0] LOSS_LIM = 8'(`LDC_CLK_LOSS_CYC - 1);

  logic [2:0]           sclk_sq;
  logic [2:0]           cs_sq;
  logic [1:0]           sdi_sq;
  logic                 sclk_rise;
  logic                 sclk_fall;
  logic                 cs_act;
  ldc_pkg::ldc_spi_e    state_q;
  logic [2:0]           bit_cnt_q;
  logic [7:0]           shift_in_q;
  logic [7:0]           shift_out_q;
  logic                 rw_q;
  logic [6:0]           addr_q;
  logic                 wr_stb_q;
  logic [6:0]           wr_addr_q;
  logic [7:0]           wr_data_q;
  logic [6:0]           rd_addr;
  logic [7:0]           rd_byte;
  logic [7:0]           pwr_q;
  logic [7:0]           ctl_q;
  logic [7:0]           stab_q;
  logic [7:0]           dly_q;
  logic                 en_link_q;
  logic                 lock_link;
  logic                 beat_link;
  logic [1:0]           lock_sq;
  logic [2:0]           beat_sq;
  logic                 beat_edge;
  logic [7:0]           loss_cnt_q;
  logic                 clk_ok_q;
  ldc_pkg::ldc_status_s stat_live;

  // Sign-magnitude phase code to a signed step count.
  function automatic logic signed [4:0] sm_to_signed(input logic [3:0] v);
    logic signed [4:0] m;
    m = $signed({2'b00, v[2:0]});
    return v[`LDC_CTL_SGN_BIT] ? -m : m;
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  // Every serial pin passes two flops before any decoding looks at it.
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      sclk_sq <= 3'h0;
      cs_sq   <= 3'h7;
      sdi_sq  <= 2'h0;
    end else begin
      sclk_sq <= {sclk_sq[1:0], spi_sclk_in};
      cs_sq   <= {cs_sq[1:0], spi_cs_n_in};
      sdi_sq  <= {sdi_sq[0], spi_sdio_in};
    end
  end

  assign sclk_rise = sclk_sq[1] & ~sclk_sq[2];
  assign sclk_fall = ~sclk_sq[1] & sclk_sq[2];
  assign cs_act    = ~cs_sq[1];

  // --------------------------------------------------------------------------
  // Serial register port
  // --------------------------------------------------------------------------
  // Next read address: fresh from the instruction, or stepping down for streaming.
  assign rd_addr = (state_q == ldc_pkg::LDC_SPI_INSTR) ? {shift_in_q[5:0], sdi_sq[1]} : 7'(addr_q - 7'h01);

  // Read decode; status is taken live here so each byte is a momentary snapshot.
  always_comb begin
    case (rd_addr)
      `LDC_ADDR_PWR:  rd_byte = pwr_q;
      `LDC_ADDR_CTL:  rd_byte = ctl_q;
      `LDC_ADDR_STAB: rd_byte = stab_q;
      `LDC_ADDR_STAT: rd_byte = stat_live; // R7
      `LDC_ADDR_DLY:  rd_byte = dly_q;
      default:        rd_byte = 8'h00;
    endcase
  end

  // Instruction byte then data bytes, most significant bit first; the address
  // steps down after each data byte so multi-byte transfers walk toward zero.
  always_ff @(posedge clk_sys_in) begin
    wr_stb_q <= 1'b0;
    if (!reset_n_in || !cs_act) begin
      state_q         <= ldc_pkg::LDC_SPI_IDLE;
      bit_cnt_q       <= 3'h0;
      shift_in_q      <= 8'h00;
      shift_out_q     <= 8'h00;
      rw_q            <= 1'b0;
      addr_q          <= 7'h00;
      wr_addr_q       <= 7'h00;
      wr_data_q       <= 8'h00;
      spi_sdio_out    <= 1'b0;
      spi_sdio_oe_out <= 1'b0;
    end else begin
      case (state_q)
        ldc_pkg::LDC_SPI_IDLE: begin
          state_q <= ldc_pkg::LDC_SPI_INSTR;
        end
        ldc_pkg::LDC_SPI_INSTR: begin
          if (sclk_rise) begin
            shift_in_q <= {shift_in_q[6:0], sdi_sq[1]};
            bit_cnt_q  <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7) begin
              rw_q        <= shift_in_q[6];
              addr_q      <= rd_addr;
              shift_out_q <= rd_byte;
              state_q     <= ldc_pkg::LDC_SPI_DATA;
            end
          end
        end
        ldc_pkg::LDC_SPI_DATA: begin
          if (sclk_rise) begin
            shift_in_q <= {shift_in_q[6:0], sdi_sq[1]};
            bit_cnt_q  <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7) begin
              wr_stb_q    <= ~rw_q;
              wr_addr_q   <= addr_q;
              wr_data_q   <= {shift_in_q[6:0], sdi_sq[1]};
              addr_q      <= rd_addr;
              shift_out_q <= rd_byte;
            end
          end else if (sclk_fall && rw_q) begin
            spi_sdio_out <= shift_out_q[7];
            shift_out_q  <= {shift_out_q[6:0], 1'b0};
          end
          spi_sdio_oe_out <= rw_q;
        end
        default: begin
          state_q <= ldc_pkg::LDC_SPI_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  // Status is read-only: writes to its offset and to unmapped offsets are dropped.
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      pwr_q  <= `LDC_RST_PWR;
      ctl_q  <= `LDC_RST_CTL;
      stab_q <= `LDC_RST_STAB;
      dly_q  <= `LDC_RST_DLY;
    end else if (wr_stb_q) begin
      case (wr_addr_q)
        `LDC_ADDR_PWR:  pwr_q  <= wr_data_q;
        `LDC_ADDR_CTL:  ctl_q  <= wr_data_q; // R10
        `LDC_ADDR_STAB: stab_q <= wr_data_q;
        `LDC_ADDR_DLY:  dly_q  <= wr_data_q;
        default:        pwr_q  <= pwr_q;
      endcase
    end
  end

  // Registered controls toward the loop and the output stage.
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      en_link_q      <= 1'b0;
      dcc_enable_out <= 1'b0;
      phase_step_out <= 5'sd0;
    end else begin
      // A live least-significant delay cell keeps the loop from locking.
      en_link_q      <= ctl_q[`LDC_CTL_EN_BIT] & ~dly_q[`LDC_DLY_LSB_BIT]; // R10
      dcc_enable_out <= ctl_q[`LDC_CTL_EN_BIT] & ctl_q[`LDC_CTL_DCC_BIT]; // R10
      phase_step_out <= sm_to_signed(ctl_q[3:0]); // R13
    end
  end

  assign output_current_off_out = pwr_q[`LDC_PWR_OFF_BIT];

  // --------------------------------------------------------------------------
  // Clock supervision and status
  // --------------------------------------------------------------------------
  // Lock level and heartbeat cross by two flops; the edge test reads the second.
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      lock_sq <= 2'h0;
      beat_sq <= 3'h0;
    end else begin
      lock_sq <= {lock_sq[0], lock_link};
      beat_sq <= {beat_sq[1:0], beat_link};
    end
  end

  assign beat_edge = beat_sq[1] ^ beat_sq[2];

  // The link clock may stop at any time, so its absence is judged here by timeout.
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      loss_cnt_q <= 8'h00;
      clk_ok_q   <= 1'b0;
    end else if (beat_edge) begin
      loss_cnt_q <= 8'h00;
      clk_ok_q   <= 1'b1; // R5
    end else if (loss_cnt_q == LOSS_LIM) begin
      clk_ok_q   <= 1'b0; // R5
    end else begin
      loss_cnt_q <= loss_cnt_q + 8'h01;
    end
  end

  // A stale lock from a stopped clock is masked by the clock-present check.
  always_comb begin
    stat_live         = '0;
    stat_live.running = ctl_q[`LDC_CTL_EN_BIT]; // R3
    stat_live.clk_ok  = clk_ok_q; // R5
    stat_live.locked  = lock_sq[1] & clk_ok_q & ctl_q[`LDC_CTL_EN_BIT]; // R4 R11
    stat_live.warn[2] = ctl_q[`LDC_CTL_EN_BIT] & dly_q[`LDC_DLY_LSB_BIT]; // R6
    stat_live.warn[1] = ctl_q[2:0] == `LDC_PH_BAD_MAG; // R6
    stat_live.warn[0] = ctl_q[2:0] >= `LDC_PH_WARN_MAG; // R6
  end

  ldc_link u_link (
    .forwarded_data_clock_in (forwarded_data_clock_in),
    .reset_n_in              (reset_n_in),
    .loop_en_in              (en_link_q),
    .slow_in                 (stab_q[`LDC_STAB_SLOW]),
    .out_off_in              (pwr_q[`LDC_PWR_OFF_BIT]),
    .data_in                 (lvds_data_in),
    .lock_out                (lock_link),
    .beat_out                (beat_link),
    .sample_out              (sample_out),
    .valid_out               (sample_valid_out)
  );

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_stat_load;
    state_q == ldc_pkg::LDC_SPI_INSTR && sclk_rise && bit_cnt_q == 3'h7 && rd_addr == `LDC_ADDR_STAT;
  endsequence

  a_enable_write: assert property ( // R10
    wr_stb_q && wr_addr_q == `LDC_ADDR_CTL && wr_data_q == 8'hC0 |=> stat_live.running ##2 dcc_enable_out)
    else $error("loop enable write not applied");
  a_run_clear: assert property ( // R3
    $fell(ctl_q[`LDC_CTL_EN_BIT]) |-> !stat_live.running && !stat_live.locked ##1 !en_link_q && !dcc_enable_out)
    else $error("running bit stayed after disable");
  a_lock_clock: assert property ( // R4
    stat_live.locked |-> clk_ok_q && lock_sq[1])
    else $error("lock shown without clock");
  a_clk_seen: assert property ( // R5
    beat_edge |=> clk_ok_q)
    else $error("clock edge not reported");
  a_clk_lost: assert property ( // R5
    loss_cnt_q == LOSS_LIM && !beat_edge |=> !clk_ok_q)
    else $error("clock loss not reported");
  a_warn_cell: assert property ( // R6
    ctl_q[`LDC_CTL_EN_BIT] && dly_q[`LDC_DLY_LSB_BIT] |-> stat_live.warn[2])
    else $error("delay cell warning missing");
  a_stat_snap: assert property ( // R7
    s_stat_load |=> shift_out_q == $past(stat_live))
    else $error("status snapshot wrong");
  a_lock_pattern: assert property ( // R11
    stat_live.locked && ctl_q[3:0] == 4'h0 && !dly_q[0] |-> stat_live[7:4] == 4'h8)
    else $error("locked pattern not 1000b");
  a_phase_sign: assert property ( // R13
    ctl_q[`LDC_CTL_SGN_BIT] && ctl_q[2:0] != 3'h0 |=> phase_step_out + $signed({2'b00, $past(ctl_q[2:0])}) == 5'sd0)
    else $error("phase sign wrong");

endmodule

// [bench/ldc_host_model.sv]
// Host model: forwarded data clock and data lanes of the source-synchronous link.
module ldc_host_model (
  // Control from the bench
  input  wire logic        run_in,
  input  wire logic [15:0] word_in,
  // Link pins
  output logic             fwd_clk_out,
  output logic [15:0]      lane_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // The clock only runs while run_in is high and stands low otherwise.
  // The lanes move a quarter period ahead of each edge, which stands in for the shifted sampling clock.
  // An idle host keeps toggling the lanes so that no stale word can be captured by accident.
  initial begin
    fwd_clk_out = 1'b0;
    lane_out    = 16'h0000;
    #7;
    forever begin
      #20;
      if (run_in) lane_out = fwd_clk_out ? ~word_in : word_in;
      else lane_out = ~lane_out;
      #20;
      fwd_clk_out = run_in ? ~fwd_clk_out : 1'b0;
    end
  end
endmodule

// [bench/lvds_dll_capture_setup_test.sv]
// Self-checking bench for the forwarded-clock capture setup block.
`include "ldc_defs.svh"

module lvds_dll_capture_setup_test;
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic                 clk_sys_in = 1'b0;
  logic                 reset_n_in = 1'b0;
  logic                 sclk       = 1'b0;
  logic                 cs_n       = 1'b1;
  logic                 sdio_in    = 1'b0;
  logic                 sdio_out;
  logic                 sdio_oe;
  logic                 oe_seen    = 1'b0;
  logic                 forwarded_data_clock;
  logic [15:0]          lanes;
  ldc_pkg::ldc_sample_s sample;
  logic                 sample_valid;
  logic                 cur_off;
  logic                 dcc_en;
  logic signed [4:0]    phase;
  logic                 run       = 1'b0;
  logic [15:0]          word      = 16'h0000;
  int                   bad_count = 0;
  int                   compares  = 0;
  int                   seed      = 32'h6C3B;
  logic [31:0]          exp_q [$];
  logic [31:0]          got_v;
  logic                 got_k;
  event                 got_ev;
  logic [6:0]           rst_a [6] = '{`LDC_ADDR_PWR, `LDC_ADDR_CTL, `LDC_ADDR_STAB, `LDC_ADDR_STAT, `LDC_ADDR_DLY, 7'h33};
  logic [7:0]           ctl_t [4] = '{8'hC7, 8'hCE, 8'hC3, 8'hCB};
  logic [4:0]           ph_t [4]  = '{5'h07, 5'h1A, 5'h03, 5'h1D};
  logic [7:0]           wrn_t [4] = '{8'h30, 8'h10, 8'h00, 8'h00};

  always #2 clk_sys_in = ~clk_sys_in;

  ldc_top u_dut (
    .clk_sys_in              (clk_sys_in),
    .reset_n_in              (reset_n_in),
    .spi_sclk_in             (sclk),
    .spi_cs_n_in             (cs_n),
    .spi_sdio_in             (sdio_in),
    .spi_sdio_out            (sdio_out),
    .spi_sdio_oe_out         (sdio_oe),
    .forwarded_data_clock_in (forwarded_data_clock),
    .lvds_data_in            (lanes),
    .sample_out              (sample),
    .sample_valid_out        (sample_valid),
    .output_current_off_out  (cur_off),
    .dcc_enable_out          (dcc_en),
    .phase_step_out          (phase)
  );

  ldc_host_model u_host (
    .run_in      (run),
    .word_in     (word),
    .fwd_clk_out (forwarded_data_clock),
    .lane_out    (lanes)
  );

  // ---------------------------------------------------------------------------
  // Checking
  // ---------------------------------------------------------------------------
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp_byte(input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g[7:0] !== e[7:0]) begin
      bad_count++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e[7:0], g[7:0]);
    end
  endtask

  task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // Results are matched with the oldest note, so notes must be queued in result order.
  always @(got_ev) begin
    if (got_k) cmp_word(exp_q.pop_front(), got_v);
    else cmp_byte(exp_q.pop_front(), got_v);
  end

  task automatic post(input logic k, input logic [31:0] v);
    got_k = k;
    got_v = v;
    -> got_ev;
    @(negedge clk_sys_in);
  endtask

  task automatic chk_pin(input logic [31:0] e, input logic [31:0] g);
    exp_q.push_back(e);
    post(1'b1, g);
  endtask

  // ---------------------------------------------------------------------------
  // Serial register port
  // ---------------------------------------------------------------------------
  // Six system cycles per sclk phase leaves margin over the two-flop synchroniser.
  task automatic half();
    repeat (6) @(negedge clk_sys_in);
  endtask

  task automatic spi_xfer(input logic [7:0] ins, input logic [7:0] wd, output logic [7:0] rdv);
    logic [15:0] sh;
    sh  = {ins, wd};
    rdv = 8'h00;
    cs_n = 1'b0;
    for (int i = 0; i < 16; i++) begin
      sdio_in = sh[15-i];
      half();
      if (i >= 8) rdv = {rdv[6:0], sdio_out};
      if (i == 12) oe_seen = sdio_oe;
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
    half();
    cs_n = 1'b1;
    half();
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    spi_xfer({1'b0, a}, d, r);
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] r;
    exp_q.push_back({24'h000000, e & m});
    spi_xfer({1'b1, a}, 8'h00, r);
    post(1'b0, {24'h000000, r & m});
    chk_pin(32'h1, {31'h0, oe_seen});
  endtask

  // ---------------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge clk_sys_in);
    bad_count++;
    finish_test();
  end

  initial begin
    int n;
    repeat (12) @(negedge clk_sys_in);
    reset_n_in = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    foreach (rst_a[i]) rd(rst_a[i], 8'hFF, 8'h00);
    $display("test reset values done");

    // The link logic only clears on its own clock edges, so it gets a second,
    // longer reset with the forwarded clock running, which then stops again.
    run = 1'b1;
    reset_n_in = 1'b0;
    repeat (100) @(negedge clk_sys_in);
    run = 1'b0;
    repeat (20) @(negedge clk_sys_in);
    reset_n_in = 1'b1;
    repeat (4) @(negedge clk_sys_in);

    wr(`LDC_ADDR_PWR, 8'h80);
    chk_pin(32'h1, {31'h0, cur_off});
    rd(`LDC_ADDR_PWR, 8'hFF, 8'h80);
    rd(`LDC_ADDR_STAT, 8'hFF, 8'h00);
    run = 1'b1;
    repeat (60) @(negedge clk_sys_in);
    rd(`LDC_ADDR_STAT, 8'hFF, 8'h04);
    wr(`LDC_ADDR_PWR, 8'h00);
    chk_pin(32'h0, {31'h0, cur_off});
    $display("test clock detect done");

    wr(`LDC_ADDR_DLY, 8'hFE);
    wr(`LDC_ADDR_STAB, 8'h86);
    wr(`LDC_ADDR_CTL, 8'hC0);
    chk_pin(32'h1, {31'h0, dcc_en});
    chk_pin(32'h0, {27'h0, phase});
    rd(`LDC_ADDR_STAT, 8'hFF, 8'h05);
    repeat (3200) @(negedge clk_sys_in);
    rd(`LDC_ADDR_STAT, 8'hF0, 8'h80);
    wr(`LDC_ADDR_STAT, 8'hFF);
    rd(`LDC_ADDR_STAT, 8'hFF, 8'h85);
    $display("test loop lock done");

    n = 0;
    while (sample_valid !== 1'b1 && n < 500) begin
      @(negedge clk_sys_in);
      n++;
    end
    if (n == 500) begin
      bad_count++;
      finish_test();
    end
    for (int i = 0; i < 4; i++) begin
      word = 16'($random(seed));
      repeat (60) @(negedge clk_sys_in);
      chk_pin({word, ~word}, sample);
    end
    wr(`LDC_ADDR_PWR, 8'h80);
    repeat (60) @(negedge clk_sys_in);
    chk_pin(32'h0, {31'h0, sample_valid});
    wr(`LDC_ADDR_PWR, 8'h00);
    $display("test capture done");

    foreach (ctl_t[i]) begin
      wr(`LDC_ADDR_CTL, ctl_t[i]);
      chk_pin({27'h0, ph_t[i]}, {27'h0, phase});
      rd(`LDC_ADDR_STAT, 8'h70, wrn_t[i]);
    end
    wr(`LDC_ADDR_CTL, 8'hC0);
    wr(`LDC_ADDR_DLY, 8'hFF);
    rd(`LDC_ADDR_STAT, 8'h40, 8'h40);
    wr(`LDC_ADDR_DLY, 8'hFE);
    wr(`LDC_ADDR_CTL, 8'h40);
    chk_pin(32'h0, {31'h0, dcc_en});
    rd(`LDC_ADDR_STAT, 8'h01, 8'h00);
    $display("test phase and warnings done");

    // The loss timeout is 120 cycles; 200 covers it with the link beat jitter included.
    wr(`LDC_ADDR_CTL, 8'hC0);
    run = 1'b0;
    repeat (200) @(negedge clk_sys_in);
    rd(`LDC_ADDR_STAT, 8'hFF, 8'h01);
    $display("test clock loss done");
    finish_test();
  end
endmodule
